// ==== include/lp_mem_pkg.sv ====
`default_nettype none

package lp_mem_pkg;

    localparam int ADDR_W = 13;

    // Command pins, packed as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP    = 4'h7;
    localparam logic [3:0] CMD_ACT    = 4'h3;
    localparam logic [3:0] CMD_READ   = 4'h5;
    localparam logic [3:0] CMD_WRITE  = 4'h4;
    localparam logic [3:0] CMD_BSTOP  = 4'h6;
    localparam logic [3:0] CMD_PRE    = 4'h2;
    localparam logic [3:0] CMD_AREF   = 4'h1;
    localparam logic [3:0] CMD_LOAD   = 4'h0;

    // Bit of the address that turns a precharge into a precharge-all
    localparam int PRE_ALL_BIT = 10;

    // Standard configuration register fields
    localparam int BLEN_LSB  = 0;
    localparam int BLEN_W    = 3;
    localparam int BTYPE_BIT = 3;
    localparam int RLAT_LSB  = 4;
    localparam int RLAT_W    = 3;
    localparam logic [ADDR_W-1:0] CFG_RESET = 13'h0032;
    localparam logic [ADDR_W-1:0] EXT_RESET = 13'h0000;

    localparam logic [BLEN_W-1:0] BLEN_2  = 3'h1;
    localparam logic [BLEN_W-1:0] BLEN_16 = 3'h4;
    localparam logic [RLAT_W-1:0] RLAT_2  = 3'h2;
    localparam logic [RLAT_W-1:0] RLAT_3  = 3'h3;

    localparam logic [1:0] REFRESH_NEEDED = 2'h2;

    // APB map (byte addresses)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_EXT    = 8'h08;
    localparam logic [7:0] REG_WRAP   = 8'h0C;
    localparam logic [7:0] REG_COLOUT = 8'h10;

    // Wrap register: start column in [12:0], beat index in [19:16]
    localparam int WRAP_BEAT_LSB = 16;
    localparam int WRAP_BEAT_W   = 4;

    // Status register layout
    localparam int ST_PWR_LSB  = 0;
    localparam int ST_INIT_BIT = 4;
    localparam int ST_BANK_LSB = 8;
    localparam int ST_CKE_BIT  = 12;

    typedef enum logic [2:0] {
        PWR_NORMAL, PWR_ACTIVE_PD, PWR_PRECHARGE_PD,
        PWR_SELF_REFRESH, PWR_DEEP_SLEEP
    } power_state_e;

endpackage : lp_mem_pkg

`default_nettype wire

// ==== rtl/lp_mem_power_ctrl.sv ====
// Operation
// - Clock enable low twice holds state; low-to-high with NOP exits.
// - High-to-low clock enable picks power-down, self refresh or deep sleep.
// - After full initialization every valid command is accepted.
// - Config load with both bank selects zero writes standard register.
// - Standard register kept until reprogrammed or deep sleep entered.
// - Reprogramming the configuration never changes stored array data.
// - Burst lengths 2, 4, 8, 16 for sequential and interleaved.
// - Burst wraps inside an aligned column block of burst length.
// - One programmed burst length serves reads and writes.
// - Read latency programmable to 2 or 3 cycles.
// - Burst order sequential or interleaved from the standard register.
// - Config load with bank_sel_lo zero, bank_sel_hi one writes extended.
// - NOP is chip select low, three strobes high; continues operations.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lp_mem_power_ctrl
(
    input  wire logic                         i_clock,
    input  wire logic                         i_rst,
    input  wire logic                         i_mem_clk,
    input  wire logic                         i_cke,
    input  wire logic                         i_cs_n,
    input  wire logic                         i_ras_n,
    input  wire logic                         i_cas_n,
    input  wire logic                         i_we_n,
    input  wire logic                         i_bank_sel_lo,
    input  wire logic                         i_bank_sel_hi,
    input  wire logic [lp_mem_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              o_initialized,
    output logic      [2:0]                   o_power_state,
    output logic      [2:0]                   o_read_latency
);

    // Memory clock, clock enable, four strobes, two bank selects, address
    localparam int PW = 8 + lp_mem_pkg::ADDR_W;
    localparam int AW = lp_mem_pkg::ADDR_W;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link clock edge detect
    logic [PW-1:0] pins_meta;
    logic [PW-1:0] pins_sync;
    logic          clk_prev;

    always_ff @(posedge i_clock)
    begin
        pins_meta <= {i_mem_clk, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
                      i_bank_sel_hi, i_bank_sel_lo, i_addr};
        pins_sync <= pins_meta;
    end

    // No reset: following the pin through reset avoids a false edge after it
    always_ff @(posedge i_clock)
    begin
        clk_prev <= pins_sync[PW-1];
    end

    logic          edge_now;
    logic          cke_now;
    logic [3:0]    cmd;
    logic          bsel_hi;
    logic          bsel_lo;
    logic [AW-1:0] addr;
    logic          nop_like;

    assign edge_now = pins_sync[PW-1] & ~clk_prev;
    assign cke_now  = pins_sync[PW-2];
    assign bsel_hi  = pins_sync[AW+1];
    assign bsel_lo  = pins_sync[AW];
    assign addr     = pins_sync[AW-1:0];
    // Deselect reads as NOP whatever the strobes do
    assign cmd      = pins_sync[PW-3] ? lp_mem_pkg::CMD_NOP
                                      : pins_sync[PW-3 -: 4];
    assign nop_like = (cmd == lp_mem_pkg::CMD_NOP);

    ////////////////////////////////////////////////////////////////////////
    // Clock enable history
    logic cke_prev;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            cke_prev <= 1'b1;
        else if (edge_now)
            cke_prev <= cke_now;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank tracking; commands only act while clock enable stays high
    logic [3:0] bank_open;
    logic       cmd_live;
    logic [1:0] bank_idx;
    lp_mem_pkg::power_state_e pwr;

    assign cmd_live = edge_now & cke_prev & cke_now
                    & (pwr == lp_mem_pkg::PWR_NORMAL);
    assign bank_idx = {bsel_hi, bsel_lo};

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            bank_open <= 4'h0;
        else if (pwr == lp_mem_pkg::PWR_DEEP_SLEEP)
            bank_open <= 4'h0;
        else if (cmd_live && cmd == lp_mem_pkg::CMD_ACT)
            bank_open[bank_idx] <= 1'b1;
        else if (cmd_live && cmd == lp_mem_pkg::CMD_PRE)
        begin
            if (addr[lp_mem_pkg::PRE_ALL_BIT])
                bank_open <= 4'h0;
            else
                bank_open[bank_idx] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            pwr <= lp_mem_pkg::PWR_NORMAL;
        else if (edge_now)
        begin
            case (pwr)
                lp_mem_pkg::PWR_NORMAL:
                    if (cke_prev && !cke_now)
                    begin
                        if (bank_open != 4'h0)
                        begin
                            if (nop_like)
                                pwr <= lp_mem_pkg::PWR_ACTIVE_PD;
                        end
                        else if (nop_like)
                            pwr <= lp_mem_pkg::PWR_PRECHARGE_PD;
                        else if (cmd == lp_mem_pkg::CMD_AREF)
                            pwr <= lp_mem_pkg::PWR_SELF_REFRESH;
                        else if (cmd == lp_mem_pkg::CMD_BSTOP)
                            pwr <= lp_mem_pkg::PWR_DEEP_SLEEP;
                    end
                default:
                    // Low on both edges holds; rising with NOP leaves
                    if (!cke_prev && cke_now && nop_like)
                        pwr <= lp_mem_pkg::PWR_NORMAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Initialization progress; deep sleep throws it all away
    logic       seen_pre_all;
    logic [1:0] refresh_cnt;
    logic       std_loaded;
    logic       ext_loaded;
    logic       is_load;

    assign is_load = cmd_live && cmd == lp_mem_pkg::CMD_LOAD;

    always_ff @(posedge i_clock)
    begin
        if (i_rst || pwr == lp_mem_pkg::PWR_DEEP_SLEEP)
        begin
            seen_pre_all <= 1'b0;
            refresh_cnt  <= 2'h0;
            std_loaded   <= 1'b0;
            ext_loaded   <= 1'b0;
        end
        else if (cmd_live)
        begin
            if (cmd == lp_mem_pkg::CMD_PRE
                && addr[lp_mem_pkg::PRE_ALL_BIT])
                seen_pre_all <= 1'b1;
            if (cmd == lp_mem_pkg::CMD_AREF && seen_pre_all
                && refresh_cnt != lp_mem_pkg::REFRESH_NEEDED)
                refresh_cnt <= refresh_cnt + 2'h1;
            if (is_load && !bsel_lo && !bsel_hi)
                std_loaded <= 1'b1;
            if (is_load && !bsel_lo && bsel_hi)
                ext_loaded <= 1'b1;
        end
    end

    assign o_initialized = seen_pre_all && std_loaded && ext_loaded
        && refresh_cnt == lp_mem_pkg::REFRESH_NEEDED;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; only the register file changes, never data
    logic [AW-1:0] cfg;
    logic [AW-1:0] ext_cfg;

    always_ff @(posedge i_clock)
    begin
        if (i_rst || pwr == lp_mem_pkg::PWR_DEEP_SLEEP)
            cfg <= lp_mem_pkg::CFG_RESET;
        else if (is_load && !bsel_lo && !bsel_hi)
            cfg <= addr;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst || pwr == lp_mem_pkg::PWR_DEEP_SLEEP)
            ext_cfg <= lp_mem_pkg::EXT_RESET;
        else if (is_load && !bsel_lo && bsel_hi)
            ext_cfg <= addr;
    end

    logic [2:0] blen_code;
    logic       interleave;

    assign blen_code  = cfg[lp_mem_pkg::BLEN_LSB +: lp_mem_pkg::BLEN_W];
    assign interleave = cfg[lp_mem_pkg::BTYPE_BIT];

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_read_latency <= lp_mem_pkg::RLAT_3;
        else
            o_read_latency <=
                cfg[lp_mem_pkg::RLAT_LSB +: lp_mem_pkg::RLAT_W];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_power_state <= 3'h0;
        else
            o_power_state <= 3'(pwr);
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst wrap column generator, shared by reads and writes
    logic [AW-1:0] wrap_start;
    logic [3:0]    wrap_beat;
    logic [AW-1:0] wrap_mask;
    logic [AW-1:0] wrap_col;

    always_comb
    begin
        // Reserved lengths fall back to no wrap offset at all
        if (blen_code >= lp_mem_pkg::BLEN_2
            && blen_code <= lp_mem_pkg::BLEN_16)
            wrap_mask = AW'((13'h0001 << blen_code) - 13'h0001);
        else
            wrap_mask = 13'h0000;
        if (interleave)
            wrap_col = (wrap_start & ~wrap_mask)
                     | ((wrap_start ^ AW'(wrap_beat)) & wrap_mask);
        else
            wrap_col = (wrap_start & ~wrap_mask)
                     | ((wrap_start + AW'(wrap_beat)) & wrap_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    logic access;
    logic mapped;

    assign access = psel & penable;
    assign pready = 1'b1;
    assign mapped = paddr == lp_mem_pkg::REG_STATUS
                 || paddr == lp_mem_pkg::REG_CFG
                 || paddr == lp_mem_pkg::REG_EXT
                 || paddr == lp_mem_pkg::REG_WRAP
                 || paddr == lp_mem_pkg::REG_COLOUT;
    assign pslverr = access & ~mapped;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            wrap_start <= 13'h0000;
            wrap_beat  <= 4'h0;
        end
        else if (access && pwrite && paddr == lp_mem_pkg::REG_WRAP)
        begin
            wrap_start <= pwdata[AW-1:0];
            wrap_beat  <=
                pwdata[lp_mem_pkg::WRAP_BEAT_LSB +: lp_mem_pkg::WRAP_BEAT_W];
        end
    end

    always_comb
    begin
        prdata = 32'h00000000;
        if (psel && !pwrite)
        begin
            case (paddr)
                lp_mem_pkg::REG_STATUS:
                begin
                    prdata[lp_mem_pkg::ST_PWR_LSB +: 3] = 3'(pwr);
                    prdata[lp_mem_pkg::ST_INIT_BIT]     = o_initialized;
                    prdata[lp_mem_pkg::ST_BANK_LSB +: 4] = bank_open;
                    prdata[lp_mem_pkg::ST_CKE_BIT]      = cke_prev;
                end
                lp_mem_pkg::REG_CFG:    prdata[AW-1:0] = cfg;
                lp_mem_pkg::REG_EXT:    prdata[AW-1:0] = ext_cfg;
                lp_mem_pkg::REG_WRAP:
                begin
                    prdata[AW-1:0] = wrap_start;
                    prdata[lp_mem_pkg::WRAP_BEAT_LSB +: 4] = wrap_beat;
                end
                lp_mem_pkg::REG_COLOUT: prdata[AW-1:0] = wrap_col;
                default:                prdata = 32'h00000000;
            endcase
        end
    end

endmodule : lp_mem_power_ctrl

`default_nettype wire

// ==== tb/lp_mem_power_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module lp_mem_power_ctrl_asserts
(
    input wire logic                          i_clock,
    input wire logic                          i_rst,
    input wire logic                          i_cke,
    input wire logic                          i_cs_n,
    input wire logic                          i_ras_n,
    input wire logic                          i_cas_n,
    input wire logic                          i_we_n,
    input wire logic                          i_bank_sel_lo,
    input wire logic                          i_bank_sel_hi,
    input wire logic [lp_mem_pkg::ADDR_W-1:0] i_addr,
    input wire logic                          o_initialized,
    input wire logic [2:0]                    o_power_state,
    input wire logic [2:0]                    o_read_latency
);
    logic [3:0] cmd;
    logic       ld_std;
    logic       ds_ent;
    logic [4:0] quiet;
    logic [2:0] lat_seen;

    assign cmd    = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    assign ld_std = cmd == lp_mem_pkg::CMD_LOAD && i_cke && !i_bank_sel_lo
                    && !i_bank_sel_hi;
    assign ds_ent = cmd == lp_mem_pkg::CMD_BSTOP && !i_cke;

    // Cycles since the pins last showed a standard load or deep sleep entry
    always_ff @(posedge i_clock)
    begin
        if (i_rst || ld_std || ds_ent)
            quiet <= 5'h0;
        else if (quiet != 5'h1F)
            quiet <= quiet + 5'h1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst || ds_ent)
            lat_seen <= 3'h3;
        else if (ld_std)
            lat_seen <= i_addr[6:4];
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // Sync and edge detection put up to 24 system clocks after a pin change
    property enters(logic [3:0] c, logic [2:0] s);
        $fell(i_cke) && cmd == c && o_initialized && o_power_state == 3'h0
            |-> ##[1:24] o_power_state == s;
    endproperty

    AST_HOLD_LOW: assert property ((!i_cke)[*8] ##0 o_power_state != 3'h0
        |=> $stable(o_power_state)) else $error("state moved with cke low");
    AST_EXIT: assert property ($rose(i_cke) && o_power_state != 3'h0
        && (i_cs_n || cmd == lp_mem_pkg::CMD_NOP)
        |-> ##[1:24] o_power_state == 3'h0) else $error("no exit");
    AST_ENTRY_PD: assert property ($fell(i_cke) && o_initialized
        && cmd == lp_mem_pkg::CMD_NOP && o_power_state == 3'h0
        |-> ##[1:24] o_power_state inside {3'h1, 3'h2})
        else $error("no power-down entry");
    AST_ENTRY_SR: assert property (enters(lp_mem_pkg::CMD_AREF, 3'h3))
        else $error("no self refresh entry");
    AST_ENTRY_DS: assert property (enters(lp_mem_pkg::CMD_BSTOP, 3'h4))
        else $error("no deep sleep entry");
    AST_INIT_FALL: assert property ($fell(o_initialized)
        |-> ##[0:3] o_power_state == 3'h4) else $error("init lost");
    AST_LAT_HOLD: assert property ($changed(o_read_latency) |-> quiet < 5'h8)
        else $error("latency changed without a load");
    AST_LAT_FOLLOWS: assert property (quiet == 5'hA
        |-> o_read_latency == lat_seen) else $error("latency not loaded");

    cover property (o_power_state == 3'h3);
    cover property ($rose(o_initialized));
    cover property (quiet == 5'h10 && lat_seen == 3'h2);
endmodule : lp_mem_power_ctrl_asserts

bind lp_mem_power_ctrl lp_mem_power_ctrl_asserts u_lp_mem_power_ctrl_asserts
(
    .i_clock, .i_rst, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
    .i_bank_sel_lo, .i_bank_sel_hi, .i_addr, .o_initialized,
    .o_power_state, .o_read_latency
);

`default_nettype wire

// ==== tb/mem_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model
#(
    parameter int STARTUP_CLKS = 1250
)
(
    output logic        o_mem_clk,
    output logic        o_cke,
    output logic [3:0]  o_cmd,
    output logic [1:0]  o_bank,
    output logic [12:0] o_addr
);
    // Odd offset keeps the memory clock unrelated in phase to the system one
    initial
    begin
        o_mem_clk = 1'b0;
        #37;
        forever #80 o_mem_clk = ~o_mem_clk;
    end

    initial
    begin
        o_cke  = 1'b1;
        o_cmd  = lp_mem_pkg::CMD_NOP;
        o_bank = 2'h0;
        o_addr = 13'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins change on the falling edge, half a period clear of sampling
    task automatic cmd(input logic [3:0] c, input logic k,
                       input logic [1:0] b, input logic [12:0] a);
        @(negedge o_mem_clk);
        o_cmd  <= c;
        o_cke  <= k;
        o_bank <= b;
        o_addr <= a;
        @(negedge o_mem_clk);
        o_cmd  <= lp_mem_pkg::CMD_NOP;
        o_bank <= ~b;
        o_addr <= ~a;
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) @(posedge o_mem_clk);
    endtask : idle

    // No reads are ever issued, so read spacing holds trivially
    task automatic init_seq(input logic [12:0] std, input logic [12:0] ext);
        idle(STARTUP_CLKS);
        cmd(lp_mem_pkg::CMD_PRE, 1'b1, 2'h0, 13'h0400);
        repeat (2) cmd(lp_mem_pkg::CMD_AREF, 1'b1, 2'h0, 13'h0);
        cmd(lp_mem_pkg::CMD_LOAD, 1'b1, 2'h0, std);
        cmd(lp_mem_pkg::CMD_LOAD, 1'b1, 2'h2, ext);
    endtask : init_seq
endmodule : mem_ctrl_model

`default_nettype wire

// ==== tb/lp_mem_power_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module lp_mem_power_ctrl_tb_top;
    logic        i_clock;
    logic        i_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        o_initialized;
    logic [2:0]  o_power_state;
    logic [2:0]  o_read_latency;
    logic        mem_clk;
    logic        cke;
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [12:0] addr;
    logic [31:0] rdata;
    logic        rerr;
    logic [12:0] cfg;
    logic [12:0] col;
    logic [3:0]  beat;
    int          n_errors = 0;
    int          num_checks = 0;

    mem_ctrl_model u_mem_ctrl_model (.o_mem_clk(mem_clk), .o_cke(cke),
        .o_cmd(cmd), .o_bank(bank), .o_addr(addr));

    lp_mem_power_ctrl u_lp_mem_power_ctrl (.i_clock, .i_rst,
        .i_mem_clk(mem_clk), .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]),
        .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_bank_sel_lo(bank[0]),
        .i_bank_sel_hi(bank[1]), .i_addr(addr), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .o_initialized,
        .o_power_state, .o_read_latency);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask : rd

    // Offset inside the burst block: add for sequential, xor for interleaved
    function automatic logic [31:0] col_exp(input logic [12:0] f,
                                            input logic [12:0] c,
                                            input logic [3:0]  b);
        logic [12:0] m;
        m = (13'h1 << f[2:0]) - 13'h1;
        return {19'h0, (c & ~m)
                | ((f[3] ? c ^ {9'h0, b} : c + {9'h0, b}) & m)};
    endfunction : col_exp

    task results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    initial
    begin
        repeat (90000) @(posedge i_clock);
        n_errors++;
        results();
    end

    initial
    begin
        i_rst   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        void'($urandom(32'hB08776BF));
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(lp_mem_pkg::REG_CFG, {19'h0, lp_mem_pkg::CFG_RESET});
        chk({29'h0, o_read_latency}, 32'h3);
        chk({31'h0, o_initialized}, 32'h0);
        u_mem_ctrl_model.init_seq(13'h0022, 13'h0001);
        chk({31'h0, o_initialized}, 32'h1);
        rd(lp_mem_pkg::REG_CFG, 32'h22);
        rd(lp_mem_pkg::REG_EXT, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            cfg = {6'h0, 3'(2 + i % 2), 1'(i / 4), 3'(1 + i % 4)};
            u_mem_ctrl_model.cmd(lp_mem_pkg::CMD_LOAD,
                                 1'b1, 2'h0, cfg);
            u_mem_ctrl_model.idle(1);
            rd(lp_mem_pkg::REG_CFG, {19'h0, cfg});
            chk({29'h0, o_read_latency}, {29'h0, cfg[6:4]});
            repeat (4)
            begin
                col  = 13'($urandom);
                beat = 4'($urandom) & ((4'h1 << cfg[2:0]) - 4'h1);
                apb(1'b1, lp_mem_pkg::REG_WRAP, {12'h0, beat, 3'h0, col});
                rd(lp_mem_pkg::REG_WRAP, {12'h0, beat, 3'h0, col});
                rd(lp_mem_pkg::REG_COLOUT,
                   col_exp(cfg, col, beat));
            end
        end
        // Hand-picked corner: 16-beat interleaved, start column 0x1F5, beat 12
        apb(1'b1, lp_mem_pkg::REG_WRAP, 32'h000C01F5);
        rd(lp_mem_pkg::REG_COLOUT, 32'h000001F9);
        // Entry table: open bank, then precharged, self refresh, deep sleep
        for (int k = 0; k < 4; k++)
        begin
            if (k < 2)
                u_mem_ctrl_model.cmd(k ? lp_mem_pkg::CMD_PRE
                                       : lp_mem_pkg::CMD_ACT,
                                     1'b1, 2'h0, 13'h0400);
            u_mem_ctrl_model.cmd(k < 2 ? lp_mem_pkg::CMD_NOP : (k == 2 ?
                lp_mem_pkg::CMD_AREF : lp_mem_pkg::CMD_BSTOP),
                1'b0, 2'h0, 13'h0);
            u_mem_ctrl_model.idle(3);
            chk({29'h0, o_power_state}, 32'(k + 1));
            // Status: state, init kept until deep sleep, bank 0 open at k 0
            rd(lp_mem_pkg::REG_STATUS, 32'(k + 1)
               | (k < 3 ? 32'h10 : 32'h0) | (k == 0 ? 32'h100 : 32'h0));
            u_mem_ctrl_model.cmd(lp_mem_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0);
            u_mem_ctrl_model.idle(2);
            chk({29'h0, o_power_state}, 32'h0);
        end
        rd(lp_mem_pkg::REG_CFG, {19'h0, lp_mem_pkg::CFG_RESET});
        chk({31'h0, o_initialized}, 32'h0);
        u_mem_ctrl_model.init_seq(13'h0033, 13'h0002);
        chk({31'h0, o_initialized}, 32'h1);
        apb(1'b1, lp_mem_pkg::REG_CFG, 32'h0);
        rd(lp_mem_pkg::REG_CFG, 32'h33);
        rd(8'h14, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        results();
    end
endmodule : lp_mem_power_ctrl_tb_top

`default_nettype wire
